/* rtl/alu_core.sv */
`timescale 1ns/10ps
module alu_core
    import alu_exec_pkg::*;
(
    // operation and operands
    input  wire op_t    op,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire flags_t flagsIn,
    // result
    output logic [7:0] res,
    output flags_t     flagsOut,
    output logic       writeRes
);
    logic [8:0] sum;
    logic [7:0] bv;
    logic       cin;
    logic       isSub;
    logic       arith;
    logic       logic3;
    logic [7:0] lres;

    always_comb begin
        isSub  = 1'b0;
        cin    = 1'b0;
        bv     = b;
        arith  = 1'b0;
        logic3 = 1'b0;
        lres   = a;
        writeRes = 1'b1;
        case (op)
            OP_ADD: begin
                arith = 1'b1;
            end
            OP_ADD_CARRY: begin
                arith = 1'b1;
                cin   = flagsIn.c;
            end
            OP_SUB, OP_SUBTRACT_CONSTANT: begin
                arith = 1'b1;
                isSub = 1'b1;
            end
            OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW: begin
                arith = 1'b1;
                isSub = 1'b1;
                cin   = flagsIn.c;
            end
            OP_AND, OP_AND_WITH_CONSTANT: begin
                logic3 = 1'b1;
                lres   = a & b;
            end
            OP_OR, OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS: begin
                logic3 = 1'b1;
                lres   = a | b;
            end
            OP_CLEAR_MASK_BITS: begin
                logic3 = 1'b1;
                lres   = a & (ALL_ONES - b);
            end
            OP_TEST_REGISTER: begin
                logic3 = 1'b1;
                lres   = a & a;
                writeRes = 1'b0;
            end
            OP_EXCLUSIVE_OR_REGS: begin
                logic3 = 1'b1;
                lres   = a ^ b;
            end
            OP_CLEAR_REGISTER: begin
                logic3 = 1'b1;
                lres   = a ^ a;
            end
            OP_INCREMENT: begin
                logic3 = 1'b1;
                lres   = a + 8'h01;
            end
            OP_DECREMENT: begin
                logic3 = 1'b1;
                lres   = a - 8'h01;
            end
            OP_TWOS_COMPLEMENT: begin
                arith = 1'b1;
                isSub = 1'b1;
                bv    = a;
            end
            OP_SET_REGISTER: begin
                lres = ALL_ONES;
            end
            OP_ONES_COMPLEMENT: begin
                lres = ALL_ONES - a;
            end
            default: begin
                writeRes = 1'b0;
            end
        endcase
    end

    // negation computes zero minus the operand on the same subtractor
    wire [7:0] aOp = (op == OP_TWOS_COMPLEMENT) ? ALL_ZERO : a;

    always_comb begin
        if (isSub)
            sum = {1'b0, aOp} - {1'b0, bv} - {8'h00, cin};
        else
            sum = {1'b0, aOp} + {1'b0, bv} + {8'h00, cin};
    end

    wire [4:0] nib = isSub ? ({1'b0, aOp[3:0]} - {1'b0, bv[3:0]} - {4'h0, cin})
                           : ({1'b0, aOp[3:0]} + {1'b0, bv[3:0]} + {4'h0, cin});
    wire       ovAdd = (aOp[7] == bv[7]) && (sum[7] != aOp[7]);
    wire       ovSub = (aOp[7] != bv[7]) && (sum[7] != aOp[7]);

    always_comb begin
        flagsOut = flagsIn;
        res      = arith ? sum[7:0] : lres;
        if (op == OP_ONES_COMPLEMENT) begin
            flagsOut.z = (res == ALL_ZERO);
            flagsOut.n = res[7];
            flagsOut.v = 1'b0;
            flagsOut.c = 1'b1;
            flagsOut.s = res[7];
        end else if (arith) begin
            flagsOut.z = (res == ALL_ZERO);
            flagsOut.n = res[7];
            flagsOut.c = sum[8];
            flagsOut.v = isSub ? ovSub : ovAdd;
            flagsOut.h = nib[4];
            flagsOut.s = res[7] ^ (isSub ? ovSub : ovAdd);
        end else if (logic3) begin
            flagsOut.z = (res == ALL_ZERO);
            flagsOut.n = res[7];
            flagsOut.v = (op == OP_INCREMENT) ? (res == 8'h80)
                       : (op == OP_DECREMENT) ? (res == 8'h7F) : 1'b0;
            flagsOut.s = res[7] ^ flagsOut.v;
        end
    end
endmodule

/* rtl/alu_exec_pkg.sv */
package alu_exec_pkg;

    // ****************************************************************
    // operation codes
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_NOP,
        OP_ADD,
        OP_ADD_CARRY,
        OP_WORD_ADD_IMMEDIATE,
        OP_SUB,
        OP_SUBTRACT_CONSTANT,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT_CONSTANT_WITH_BORROW,
        OP_WORD_SUBTRACT_IMMEDIATE,
        OP_AND,
        OP_AND_WITH_CONSTANT,
        OP_OR,
        OP_OR_WITH_CONSTANT,
        OP_EXCLUSIVE_OR_REGS,
        OP_ONES_COMPLEMENT,
        OP_TWOS_COMPLEMENT,
        OP_SET_MASK_BITS,
        OP_CLEAR_MASK_BITS,
        OP_INCREMENT,
        OP_DECREMENT,
        OP_TEST_REGISTER,
        OP_CLEAR_REGISTER,
        OP_SET_REGISTER,
        OP_POINTER_JUMP,
        OP_POINTER_CALL,
        OP_COMPARE_SKIP_EQUAL
    } op_t;

    // ****************************************************************
    // status flags and request carrier
    // ****************************************************************
    typedef struct packed {
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
        logic h;
    } flags_t;

    typedef struct packed {
        op_t        op;
        logic [4:0] dst;
        logic [4:0] src;
        logic [7:0] imm;
        logic       nextTwoWord;
    } req_t;

    localparam int REG_COUNT        = 32;
    localparam logic [4:0] Z_LOW    = 5'h1E;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP  = 16'h0001;
    localparam logic [15:0] SKIP_ONE = 16'h0002;
    localparam logic [15:0] SKIP_TWO = 16'h0003;
    localparam logic [7:0] SP_RESET = 8'hFF;

    // cycle counts per operation class
    localparam logic [1:0] CYC_ONE   = 2'd1;
    localparam logic [1:0] CYC_TWO   = 2'd2;
    localparam logic [1:0] CYC_THREE = 2'd3;

endpackage

/* rtl/eight_bit_alu_and_flow_exec.sv */
`timescale 1ns/10ps
// Behaviour
// - add with carry: sum plus carry, flags
// - word add immediate: two cycles, flags
// - word subtract immediate: two cycles, flags
// - subtract constant in one cycle
// - register subtract with borrow, one cycle
// - constant subtract with borrow, one cycle
// - and with constant, carry kept
// - or with constant, z n v
// - set mask bits by or
// - clear mask bits via complement and
// - test register keeps value, sets flags
// - ones complement is 0xFF minus value
// - twos complement is zero minus value
// - xor of two registers
// - clear register by self xor
// - increment keeps carry untouched
// - pointer jump loads pc, two cycles
// - pointer call pushes return, three cycles
// - compare skip equal, 1/2/3 cycles
module eight_bit_alu_and_flow_exec
    import alu_exec_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // instruction request
    input  wire logic        reqValid,
    input  wire req_t        req,
    output logic             reqReady,
    // architectural state
    output logic [15:0]      pc,
    output flags_t           flags,
    output logic [7:0]       stackPtr,
    output logic [15:0]      stackTop,
    output logic [1:0]       lastCycles,
    output logic             busy,
    // register debug read
    input  wire logic [4:0]  peekAddr,
    output logic [7:0]       peekData
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum {ST_IDLE, ST_WAIT} state_t;

    state_t       state_reg;
    logic [7:0]   regs_reg [REG_COUNT];
    logic [15:0]  stack_reg [256];
    logic [15:0]  pc_reg;
    flags_t       flags_reg;
    logic [7:0]   sp_reg;
    logic [1:0]   left_reg;
    logic [1:0]   cycles_reg;
    logic [7:0]   peek_reg;

    // ****************************************************************
    // operand selection
    // ****************************************************************
    wire logic       takeReq  = reqValid && reqReady;
    wire logic       useImm   = (req.op == OP_SUBTRACT_CONSTANT)
                             || (req.op == OP_SUBTRACT_CONSTANT_WITH_BORROW)
                             || (req.op == OP_AND_WITH_CONSTANT)
                             || (req.op == OP_OR_WITH_CONSTANT)
                             || (req.op == OP_SET_MASK_BITS)
                             || (req.op == OP_CLEAR_MASK_BITS);
    wire logic [7:0] opA      = regs_reg[req.dst];
    wire logic [7:0] opB      = useImm ? req.imm : regs_reg[req.src];
    wire logic [4:0] wordLo   = {req.dst[4:1], 1'b0};
    wire logic [15:0] wordIn  = {regs_reg[wordLo + 5'd1], regs_reg[wordLo]};
    wire logic [15:0] zPtr    = {regs_reg[Z_LOW + 5'd1], regs_reg[Z_LOW]};
    wire logic       isWord   = (req.op == OP_WORD_ADD_IMMEDIATE)
                             || (req.op == OP_WORD_SUBTRACT_IMMEDIATE);
    wire logic       isEqual  = (regs_reg[req.dst] == regs_reg[req.src]);

    logic [7:0]  aluRes;
    flags_t      aluFlags;
    logic        aluWrite;
    logic [15:0] wordRes;
    flags_t      wordFlags;

    alu_core u_alu (
        .op       (req.op),
        .a        (opA),
        .b        (opB),
        .flagsIn  (flags_reg),
        .res      (aluRes),
        .flagsOut (aluFlags),
        .writeRes (aluWrite)
    );

    word_core u_word (
        .sub      (req.op == OP_WORD_SUBTRACT_IMMEDIATE),
        .word     (wordIn),
        .imm      (req.imm),
        .flagsIn  (flags_reg),
        .res      (wordRes),
        .flagsOut (wordFlags)
    );

    // ****************************************************************
    // pc and cycle decode
    // ****************************************************************
    logic [15:0] pc_next;
    logic [1:0]  cycles_next;
    flags_t      flags_next;
    logic        pushRet;

    always_comb begin
        pc_next     = pc_reg + PC_STEP;
        cycles_next = CYC_ONE;
        flags_next  = aluFlags;
        pushRet     = 1'b0;
        case (req.op)
            OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
                flags_next  = wordFlags;
                cycles_next = CYC_TWO;
            end
            OP_POINTER_JUMP: begin
                pc_next     = zPtr;
                cycles_next = CYC_TWO;
                flags_next  = flags_reg;
            end
            OP_POINTER_CALL: begin
                pc_next     = zPtr;
                cycles_next = CYC_THREE;
                pushRet     = 1'b1;
                flags_next  = flags_reg;
            end
            OP_COMPARE_SKIP_EQUAL: begin
                flags_next = flags_reg;
                if (isEqual) begin
                    pc_next     = pc_reg + (req.nextTwoWord ? SKIP_TWO
                                                            : SKIP_ONE);
                    cycles_next = req.nextTwoWord ? CYC_THREE : CYC_TWO;
                end
            end
            default: begin
                cycles_next = CYC_ONE;
            end
        endcase
    end

    // ****************************************************************
    // sequencing: a request is taken only in idle, multi-cycle ops
    // hold the port busy for their remaining cycles
    // ****************************************************************
    assign reqReady = (state_reg == ST_IDLE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg  <= ST_IDLE;
            pc_reg     <= PC_RESET;
            flags_reg  <= '0;
            sp_reg     <= SP_RESET;
            left_reg   <= 2'd0;
            cycles_reg <= 2'd0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (takeReq) begin
                        pc_reg     <= pc_next;
                        flags_reg  <= flags_next;
                        cycles_reg <= cycles_next;
                        if (pushRet)
                            sp_reg <= sp_reg - 8'h01;
                        if (cycles_next != CYC_ONE) begin
                            left_reg  <= cycles_next - 2'd1;
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    left_reg <= left_reg - 2'd1;
                    if (left_reg == 2'd1)
                        state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // register file and stack: no reset, contents are undefined at start
    always_ff @(posedge clk) begin
        if (takeReq && isWord) begin
            regs_reg[wordLo]        <= wordRes[7:0];
            regs_reg[wordLo + 5'd1] <= wordRes[15:8];
        end else if (takeReq && aluWrite) begin
            regs_reg[req.dst] <= aluRes;
        end
        if (takeReq && pushRet)
            stack_reg[sp_reg] <= pc_reg + PC_STEP;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            peek_reg <= 8'h00;
        else
            peek_reg <= regs_reg[peekAddr];
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign pc         = pc_reg;
    assign flags      = flags_reg;
    assign stackPtr   = sp_reg;
    assign stackTop   = stack_reg[sp_reg + 8'h01];
    assign lastCycles = cycles_reg;
    assign busy       = (state_reg != ST_IDLE);
    assign peekData   = peek_reg;
endmodule

/* rtl/word_core.sv */
`timescale 1ns/10ps
module word_core
    import alu_exec_pkg::*;
(
    // operands
    input  wire logic        sub,
    input  wire logic [15:0] word,
    input  wire logic [7:0]  imm,
    input  wire flags_t      flagsIn,
    // result
    output logic [15:0]      res,
    output flags_t           flagsOut
);
    logic [16:0] full;

    always_comb begin
        if (sub)
            full = {1'b0, word} - {9'h000, imm};
        else
            full = {1'b0, word} + {9'h000, imm};
        res      = full[15:0];
        flagsOut = flagsIn; // half-carry kept
        flagsOut.z = (res == 16'h0000);
        flagsOut.n = res[15];
        flagsOut.c = full[16];
        flagsOut.v = sub ? (word[15] & ~res[15]) : (~word[15] & res[15]);
        flagsOut.s = flagsOut.n ^ flagsOut.v;
    end
endmodule

/* sim/alu_exec_sva.sv */
`timescale 1ns/10ps
module alu_exec_sva
    import alu_exec_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // request and state
    input wire logic        reqValid,
    input wire req_t        req,
    input wire logic        reqReady,
    input wire logic [15:0] pc,
    input wire flags_t      flags,
    input wire logic [7:0]  stackPtr,
    input wire logic [15:0] stackTop,
    input wire logic [1:0]  lastCycles,
    input wire logic        busy
);
    // ****************************************
    // timing and flag properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic tk = reqValid && reqReady;
    wire op_t  op = req.op;
    wire logic lg = op inside {OP_AND_WITH_CONSTANT, OP_OR_WITH_CONSTANT,
        OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_TEST_REGISTER,
        OP_EXCLUSIVE_OR_REGS, OP_CLEAR_REGISTER};
    property p_one;
        tk && op inside {OP_ADD_CARRY, OP_SUBTRACT_CONSTANT,
            OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW}
        |=> reqReady && lastCycles == CYC_ONE && pc == $past(pc) + PC_STEP;
    endproperty
    property p_wadd;
        tk && op == OP_WORD_ADD_IMMEDIATE |=> busy && lastCycles == CYC_TWO
            && flags.h == $past(flags.h) ##1 reqReady;
    endproperty
    property p_wsub;
        tk && op == OP_WORD_SUBTRACT_IMMEDIATE |=> !reqReady
            && flags.s == (flags.n ^ flags.v) ##1 !busy;
    endproperty
    property p_logic;
        tk && lg |=> !flags.v && flags.s == flags.n
            && flags.c == $past(flags.c) && flags.h == $past(flags.h);
    endproperty
    property p_com;
        tk && op == OP_ONES_COMPLEMENT |=> flags.c && !flags.v
            && flags.s == flags.n;
    endproperty
    property p_inc;
        tk && op == OP_INCREMENT |=> flags.c == $past(flags.c)
            && flags.h == $past(flags.h);
    endproperty
    property p_jump;
        tk && op == OP_POINTER_JUMP |=> busy && lastCycles == CYC_TWO
            && $stable(flags) ##1 reqReady && $stable(flags);
    endproperty
    property p_call;
        tk && op == OP_POINTER_CALL |=> busy
            && stackPtr == $past(stackPtr) - 8'h01
            && stackTop == $past(pc) + PC_STEP ##1 busy ##1 reqReady;
    endproperty
    property p_skip;
        tk && op == OP_COMPARE_SKIP_EQUAL |=> $stable(flags)
            && pc == $past(pc) + {14'h0000, lastCycles};
    endproperty
    a_one: assert property (p_one)
        else $error("single cycle op timing wrong");
    a_wadd: assert property (p_wadd)
        else $error("word add timing or half carry wrong");
    a_wsub: assert property (p_wsub)
        else $error("word subtract timing or sign wrong");
    a_logic: assert property (p_logic)
        else $error("logic op flags wrong");
    a_com: assert property (p_com)
        else $error("complement flags wrong");
    a_inc: assert property (p_inc)
        else $error("increment touched carry");
    a_jump: assert property (p_jump)
        else $error("pointer jump timing or flags wrong");
    a_call: assert property (p_call)
        else $error("pointer call stack or timing wrong");
    a_skip: assert property (p_skip)
        else $error("skip step or flags wrong");
    c_call: cover property (tk && op == OP_POINTER_CALL);
    c_long: cover property (tk && op == OP_COMPARE_SKIP_EQUAL && req.nextTwoWord);
    c_held: cover property (reqValid && !reqReady);
endmodule

bind eight_bit_alu_and_flow_exec alu_exec_sva u_sva (.clk(clk), .rst(rst),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .pc(pc),
    .flags(flags), .stackPtr(stackPtr), .stackTop(stackTop),
    .lastCycles(lastCycles), .busy(busy));

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import alu_exec_pkg::*;
    typedef struct {
        op_t        o;
        logic [4:0] d;
        logic [4:0] s;
        logic [7:0] k;
        logic [7:0] r;
    } row_t;
    logic        clk;
    logic        rst;
    logic        reqValid;
    req_t        req;
    logic        reqReady;
    logic [15:0] pc;
    flags_t      flags;
    logic [7:0]  stackPtr;
    logic [15:0] stackTop;
    logic [1:0]  lastCycles;
    logic        busy;
    logic [4:0]  peekAddr;
    logic [7:0]  peekData;
    logic [7:0]  rm [32];
    logic [7:0]  pend;
    logic        pv;
    flags_t      fm;
    logic [15:0] pm;
    logic [7:0]  sm;
    int          n_fail;
    int          checked;
    logic [4:0]  lr [9] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h18,
                            5'h19, 5'h1E, 5'h1F};
    logic [7:0]  lv [9] = '{8'h0F, 8'h01, 8'h80, 8'h0F, 8'h7F, 8'hF0,
                            8'hFF, 8'h34, 8'h12};
    row_t        rows [28] = '{
        '{OP_ONES_COMPLEMENT, 5'h13, 5'h00, 8'h00, 8'hF0},
        '{OP_ADD_CARRY, 5'h10, 5'h11, 8'h00, 8'h11},
        '{OP_ADD_CARRY, 5'h13, 5'h10, 8'h00, 8'h01},
        '{OP_SUBTRACT_WITH_BORROW, 5'h10, 5'h11, 8'h00, 8'h0F},
        '{OP_SUBTRACT_CONSTANT, 5'h11, 5'h00, 8'h02, 8'hFF},
        '{OP_AND_WITH_CONSTANT, 5'h11, 5'h00, 8'h3C, 8'h3C},
        '{OP_SUBTRACT_CONSTANT_WITH_BORROW, 5'h10, 5'h00, 8'h0D, 8'h01},
        '{OP_OR_WITH_CONSTANT, 5'h10, 5'h00, 8'h80, 8'h81},
        '{OP_SET_MASK_BITS, 5'h10, 5'h00, 8'h06, 8'h87},
        '{OP_CLEAR_MASK_BITS, 5'h10, 5'h00, 8'h81, 8'h06},
        '{OP_TEST_REGISTER, 5'h12, 5'h00, 8'h00, 8'h80},
        '{OP_TWOS_COMPLEMENT, 5'h12, 5'h00, 8'h00, 8'h80},
        '{OP_EXCLUSIVE_OR_REGS, 5'h10, 5'h11, 8'h00, 8'h3A},
        '{OP_INCREMENT, 5'h14, 5'h00, 8'h00, 8'h80},
        '{OP_CLEAR_REGISTER, 5'h10, 5'h00, 8'h00, 8'h00},
        '{OP_TWOS_COMPLEMENT, 5'h10, 5'h00, 8'h00, 8'h00},
        '{OP_WORD_ADD_IMMEDIATE, 5'h18, 5'h00, 8'h10, 8'h00},
        '{OP_WORD_SUBTRACT_IMMEDIATE, 5'h18, 5'h00, 8'h01, 8'hFF},
        '{OP_POINTER_JUMP, 5'h10, 5'h00, 8'h00, 8'h00},
        '{OP_POINTER_CALL, 5'h10, 5'h00, 8'h00, 8'h00},
        '{OP_COMPARE_SKIP_EQUAL, 5'h10, 5'h10, 8'h00, 8'h00},
        '{OP_COMPARE_SKIP_EQUAL, 5'h10, 5'h10, 8'h01, 8'h00},
        '{OP_COMPARE_SKIP_EQUAL, 5'h10, 5'h11, 8'h00, 8'h00},
        '{OP_ADD, 5'h11, 5'h13, 8'h00, 8'h3D},
        '{OP_SUB, 5'h11, 5'h13, 8'h00, 8'h3C},
        '{OP_AND, 5'h11, 5'h12, 8'h00, 8'h00},
        '{OP_OR, 5'h11, 5'h12, 8'h00, 8'h80},
        '{OP_DECREMENT, 5'h11, 5'h00, 8'h00, 8'h7F}};

    eight_bit_alu_and_flow_exec uut (.clk(clk), .rst(rst),
        .reqValid(reqValid), .req(req), .reqReady(reqReady), .pc(pc),
        .flags(flags), .stackPtr(stackPtr), .stackTop(stackTop),
        .lastCycles(lastCycles), .busy(busy), .peekAddr(peekAddr),
        .peekData(peekData));

    // ****************************************
    // checking and reference model
    // ****************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [13:0] ref8(op_t o, logic [7:0] a,
                                         logic [7:0] b, flags_t f);
        logic [8:0] t;
        logic [4:0] h;
        logic [7:0] x;
        logic       ci;
        if (o == OP_SET_REGISTER) return {8'hFF, f};
        ci = f.c;
        x = a;
        f.v = 1'b0;
        case (o)
            OP_ADD, OP_ADD_CARRY: begin
                if (o == OP_ADD) ci = 0;
                t = a + b + ci;
                h = a[3:0] + b[3:0] + ci;
                f.v = (a[7] == b[7]) && (t[7] != a[7]);
                f.c = t[8];
                f.h = h[4];
            end
            OP_SUB, OP_SUBTRACT_CONSTANT, OP_SUBTRACT_WITH_BORROW,
            OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_TWOS_COMPLEMENT: begin
                if (o == OP_TWOS_COMPLEMENT) begin
                    x = 8'h00;
                    b = a;
                end
                if (o inside {OP_SUB, OP_SUBTRACT_CONSTANT,
                              OP_TWOS_COMPLEMENT}) ci = 0;
                t = x - b - ci;
                h = x[3:0] - b[3:0] - ci;
                f.v = (x[7] != b[7]) && (t[7] != x[7]);
                f.c = t[8];
                f.h = h[4];
            end
            OP_ONES_COMPLEMENT: begin
                t = ~a;
                f.c = 1'b1;
            end
            OP_INCREMENT: begin
                t = a + 8'h01;
                f.v = t[7:0] == 8'h80;
            end
            OP_DECREMENT: begin
                t = a - 8'h01;
                f.v = t[7:0] == 8'h7F;
            end
            OP_AND, OP_AND_WITH_CONSTANT: t = a & b;
            OP_OR, OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS: t = a | b;
            OP_CLEAR_MASK_BITS: t = a & (ALL_ONES - b);
            OP_EXCLUSIVE_OR_REGS: t = a ^ b;
            OP_TEST_REGISTER: t = a;
            default: t = 9'h000;
        endcase
        f.n = t[7];
        f.z = t[7:0] == 8'h00;
        f.s = f.n ^ f.v;
        return {t[7:0], f};
    endfunction

    // ****************************************
    // one instruction, entered at a falling edge
    // ****************************************
    task automatic exec(op_t o, logic [4:0] d, logic [4:0] s,
                        logic [7:0] k, logic [7:0] r);
        logic [15:0] w;
        logic [15:0] u;
        logic [15:0] pe;
        logic [1:0]  cy;
        logic [7:0]  b;
        logic        ad;
        w = {rm[d | 5'h01], rm[d & 5'h1E]};
        b = o inside {OP_ADD, OP_SUB, OP_AND, OP_OR,
            OP_ADD_CARRY, OP_SUBTRACT_WITH_BORROW,
            OP_EXCLUSIVE_OR_REGS, OP_COMPARE_SKIP_EQUAL} ? rm[s] : k;
        ad = o == OP_WORD_ADD_IMMEDIATE;
        cy = CYC_ONE;
        pe = pm + PC_STEP;
        case (o)
            OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
                cy = CYC_TWO;
                u = ad ? w + k : w - k;
                fm.c = ad ? !u[15] && w[15] : u[15] && !w[15];
                fm.v = ad ? !w[15] && u[15] : w[15] && !u[15];
                fm.n = u[15];
                fm.z = u == 16'h0000;
                fm.s = fm.n ^ fm.v;
                {rm[d | 5'h01], rm[d & 5'h1E]} = u;
            end
            OP_POINTER_JUMP, OP_POINTER_CALL: begin
                cy = ad ? CYC_TWO : (o == OP_POINTER_CALL ? CYC_THREE : CYC_TWO);
                pe = {rm[31], rm[30]};
            end
            OP_COMPARE_SKIP_EQUAL: if (rm[d] == b) begin
                cy = k[0] ? CYC_THREE : CYC_TWO;
                pe = pm + {14'h0000, cy};
            end
            default: {rm[d], fm} = ref8(o, rm[d], b, fm);
        endcase
        reqValid = 1'b1;
        req = '{o, d, s, k, k[0]};
        @(posedge clk);
        @(negedge clk);
        if (pv) chk(peekData, pend);
        chk(pc, pe);
        chk(flags, fm);
        chk(lastCycles, cy);
        chk(busy, cy != CYC_ONE);
        if (o == OP_POINTER_CALL) begin
            sm = sm - 8'h01;
            chk(stackTop, pm + PC_STEP);
            chk(stackPtr, sm);
        end
        pm = pe;
        peekAddr = d;
        pend = r;
        pv = 1'b1;
        if (cy != CYC_ONE) begin
            reqValid = 1'b0;
            repeat (cy - 1) @(posedge clk);
            @(negedge clk);
            chk(reqReady, 1'b1);
        end
    endtask

    task automatic rst_chk();
        chk(pc, PC_RESET);
        chk(flags, 6'h00);
        chk(stackPtr, SP_RESET);
        chk(lastCycles, 2'h0);
        chk({busy, reqReady}, 2'h1);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (1000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        n_fail = 0;
        checked = 0;
        rst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        peekAddr = 5'h00;
        pv = 1'b0;
        pm = PC_RESET;
        sm = SP_RESET;
        fm = '0;
        repeat (10) @(negedge clk);
        rst_chk();
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            exec(OP_SET_REGISTER, lr[i], 5'h00, 8'h00, 8'hFF);
            exec(OP_AND_WITH_CONSTANT, lr[i], 5'h00, lv[i], lv[i]);
        end
        foreach (rows[i]) begin
            exec(rows[i].o, rows[i].d, rows[i].s, rows[i].k, rows[i].r);
        end
        // a request held through the busy cycles must be taken once only
        req = '{OP_POINTER_CALL, 5'h10, 5'h10, 8'h00, 1'b0};
        @(posedge clk);
        @(negedge clk);
        chk(peekData, pend);
        req = '{OP_INCREMENT, 5'h14, 5'h00, 8'h00, 1'b0};
        repeat (3) @(posedge clk);
        @(negedge clk);
        reqValid = 1'b0;
        peekAddr = 5'h14;
        chk(stackPtr, 8'hFD);
        chk(pc, 16'h1235);
        chk(lastCycles, CYC_ONE);
        @(posedge clk);
        @(negedge clk);
        chk(peekData, 8'h81);
        rst = 1'b1;
        @(negedge clk);
        rst_chk();
        stop_test();
    end
endmodule
